// *** src/ulms_cfg.svh ***
/*
  Constants for the line and modem status block: register offsets, field
  positions, reset values and bus widths.
  Assumes it is included by bare name wherever these constants are needed.
*/
`ifndef ULMS_CFG_SVH
`define ULMS_CFG_SVH

// Byte addresses of the two status registers and the helper registers.
`define ULMS_LINE_STATUS_ADDR   32'h5000_1114
`define ULMS_MODEM_STATUS_ADDR  32'h5000_1118
`define ULMS_CONTROL_ADDR       32'h5000_1120
`define ULMS_RX_DATA_ADDR       32'h5000_1124

// Line status field positions.
`define ULMS_LS_DATA_READY      0
`define ULMS_LS_OVERRUN         1
`define ULMS_LS_PARITY          2
`define ULMS_LS_FRAMING         3
`define ULMS_LS_BREAK           4
`define ULMS_LS_FIFO_ERROR      7

// Modem status field positions.
`define ULMS_MS_CTS_CHANGED     0
`define ULMS_MS_CTS             4

// Control register field positions (helper register).
`define ULMS_CTL_FIFO_EN        0
`define ULMS_CTL_PARITY_EN      1
`define ULMS_CTL_RTS            2
`define ULMS_CTL_LOOPBACK       3
`define ULMS_CTL_WIDTH          4
`define ULMS_CTL_RESET          4'h0

// Receive FIFO shape: 16 entries of data plus three error bits.
`define ULMS_FIFO_DEPTH         16
`define ULMS_FIFO_AW            4
`define ULMS_ENTRY_W            11

// Baud oversample: clock cycles per serial bit.
`define ULMS_BIT_CYCLES         16'h00D9
`define ULMS_DATA_BITS          8

`endif

// *** src/ulms_pkg.sv ***
/*
  Types shared by the line and modem status block.
  Assumes nothing beyond the constants header.
*/
package ulms_pkg;
  typedef logic [31:0] ulms_word_t;
  typedef logic [3:0]  ulms_sel_t;

  // One-hot receive states.
  typedef enum logic [4:0] {
    ULMS_RX_IDLE   = 5'b00001,
    ULMS_RX_START  = 5'b00010,
    ULMS_RX_DATA   = 5'b00100,
    ULMS_RX_PARITY = 5'b01000,
    ULMS_RX_STOP   = 5'b10000
  } ulms_rx_state_e;

  // One received character with its error marks.
  typedef struct packed {
    logic       brk;
    logic       frm;
    logic       par;
    logic [7:0] data;
  } ulms_entry_s;
endpackage : ulms_pkg

// *** src/ulms_mem_if.sv ***
/*
  Interface between the status block and its receive character store.
  Assumes a single clock shared by both ends.
*/
`timescale 1ns/1ps
`include "ulms_cfg.svh"
interface ulms_mem_if;
  import ulms_pkg::*;
  logic                      we;
  logic [`ULMS_FIFO_AW-1:0]  waddr;
  ulms_entry_s               wdata;
  logic [`ULMS_FIFO_AW-1:0]  raddr;
  ulms_entry_s               rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : ulms_mem_if

// *** src/ulms_mem.sv ***
/*
  Small receive character store with registered read data.
  Assumes the controller keeps its own pointers and counts.
*/
`timescale 1ns/1ps
`include "ulms_cfg.svh"
module ulms_mem (
  input  wire logic  i_clk,
  ulms_mem_if.mem    port
);
  import ulms_pkg::*;

  ulms_entry_s store [`ULMS_FIFO_DEPTH];

  // Write when we is high and read each cycle; the read port lags the address by one edge.
  always_ff @(posedge i_clk) begin
    if (port.we) begin
      store[port.waddr] <= port.wdata;
    end
    port.rdata <= store[port.raddr];
  end
endmodule : ulms_mem

// *** src/ulms_top.sv ***
/*
  Receive line status and modem status for a UART, with a small receiver,
  a receive FIFO and a classic Wishbone slave.
  Assumes I_RX_SERIAL and I_CTS_N are already synchronous to I_CORE_CLK.
*/
// Implementation choice: register access over Wishbone.
// Function
// - In FIFO mode a framing error shows when its character reaches the head.
// - After a framing error the low bit is taken as the next start bit.
// - A detected break also raises the framing error flag.
// - Reading line status clears framing, parity and overrun flags.
// - Parity mismatch sets parity error only while parity is enabled.
// - In FIFO mode a parity error shows when its character reaches the head.
// - A flagged break also sets the parity error flag.
// - Without FIFO a new character overwrites unread data and sets overrun.
// - With FIFO full a new character is dropped and overrun is set.
// - Data ready clears on holding read, or when the FIFO empties.
// - Clear-to-send status is the inverse of the low-active input.
// - Delta clear-to-send sets when clear-to-send changed since last read.
// - Reading modem status clears delta clear-to-send.
// - In loopback delta clear-to-send tracks request-to-send changes.
// - Delta clear-to-send sets after reset if the input is still low.
// - FIFO operation is active exactly when the FIFO enable bit is one.
// - Break is a low line longer than a whole character time.
`timescale 1ns/1ps
`include "ulms_cfg.svh"
module ulms_top (
  input  wire logic               I_CORE_CLK,
  input  wire logic               I_RST,
  input  wire logic               I_RX_SERIAL,
  input  wire logic               I_CTS_N,
  input  wire logic               I_WB_CYC,
  input  wire logic               I_WB_STB,
  input  wire logic               I_WB_WE,
  input  wire ulms_pkg::ulms_sel_t  I_WB_SEL,
  input  wire ulms_pkg::ulms_word_t I_WB_ADR,
  input  wire ulms_pkg::ulms_word_t I_WB_DAT,
  output logic                    O_WB_ACK,
  output ulms_pkg::ulms_word_t    O_WB_DAT,
  output logic                    O_RTS_N
);
  import ulms_pkg::*;

  // Full-address compare, shared by the four register selects. The whole
  // word is compared so that aliases of the status registers read as zero.
  function automatic logic addr_is(input ulms_word_t adr, input ulms_word_t reg_addr);
    addr_is = (adr == reg_addr);
  endfunction : addr_is

  // Bus decode. A request is taken only while ack is low, so a master that
  // holds its strobe through the ack edge is not served twice. Every access
  // is answered in the next cycle, mapped or not, so the bus never hangs.
  wire        bus_req    = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  wire        hit_ls     = addr_is(I_WB_ADR, `ULMS_LINE_STATUS_ADDR);
  wire        hit_ms     = addr_is(I_WB_ADR, `ULMS_MODEM_STATUS_ADDR);
  wire        hit_ctl    = addr_is(I_WB_ADR, `ULMS_CONTROL_ADDR);
  wire        hit_rx     = addr_is(I_WB_ADR, `ULMS_RX_DATA_ADDR);
  // Clearing side effects act only on the edge that takes the request and raises ack.
  wire        rd_ls      = bus_req & ~I_WB_WE & hit_ls;
  wire        rd_ms      = bus_req & ~I_WB_WE & hit_ms;
  wire        rd_rx      = bus_req & ~I_WB_WE & hit_rx;
  wire        wr_ctl     = bus_req & I_WB_WE & hit_ctl & I_WB_SEL[0];

  logic [`ULMS_CTL_WIDTH-1:0] ctl_q;
  wire        fifo_en    = ctl_q[`ULMS_CTL_FIFO_EN];
  wire        par_en     = ctl_q[`ULMS_CTL_PARITY_EN];
  wire        rts_bit    = ctl_q[`ULMS_CTL_RTS];
  wire        loopback   = ctl_q[`ULMS_CTL_LOOPBACK];

  // In loopback the outgoing request-to-send is held inactive.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      ctl_q   <= `ULMS_CTL_RESET;
      O_RTS_N <= 1'b1;
    end else begin
      if (wr_ctl) begin
        ctl_q <= I_WB_DAT[`ULMS_CTL_WIDTH-1:0];
      end
      O_RTS_N <= ~(rts_bit & ~loopback);
    end
  end

  // Receiver: bit timer, shift register and break timer.
  ulms_rx_state_e st_q;
  logic [15:0] bit_cnt_q;
  logic [3:0]  nbit_q;
  logic [7:0]  shift_q;
  logic        par_acc_q;
  logic [15:0] low_cnt_q;
  logic        brk_armed_q;

  wire        mid_bit    = (bit_cnt_q == (`ULMS_BIT_CYCLES >> 1));
  wire        bit_end    = (bit_cnt_q == `ULMS_BIT_CYCLES - 16'h0001);
  wire [15:0] char_cyc   = `ULMS_BIT_CYCLES * (par_en ? 16'h000B : 16'h000A);
  // A line low for longer than a full character is a break.
  wire        brk_hit    = ~I_RX_SERIAL & (low_cnt_q == char_cyc) & brk_armed_q;
  wire        in_stop    = (st_q == ULMS_RX_STOP) & mid_bit;
  wire        stop_bad   = in_stop & ~I_RX_SERIAL;
  wire        par_bad    = par_en & (par_acc_q != 1'b0);
  // A break delivers one zero character carrying all three marks. A frame with a
  // low stop bit is delivered with its framing mark, except an all-zero frame:
  // that one is the front of a break, and holding it back keeps a break to a
  // single character. The cost is that a lone all-zero frame with a bad stop
  // bit, followed by a quick return to idle, is not reported.
  wire        zero_frame = (shift_q == 8'h00);
  wire        char_done  = (in_stop & (I_RX_SERIAL | ~zero_frame)) | brk_hit;
  ulms_entry_s new_ch;
  assign new_ch.data = brk_hit ? 8'h00 : shift_q;
  assign new_ch.brk  = brk_hit;
  assign new_ch.frm  = stop_bad | brk_hit;
  assign new_ch.par  = (par_bad & ~brk_hit) | brk_hit;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      low_cnt_q   <= 16'h0000;
      brk_armed_q <= 1'b1;
    end else if (I_RX_SERIAL) begin
      low_cnt_q   <= 16'h0000;
      brk_armed_q <= 1'b1;
    end else if (brk_hit) begin
      brk_armed_q <= 1'b0;   // One break character per low period.
    end else if (brk_armed_q) begin
      low_cnt_q   <= low_cnt_q + 16'h0001;
    end
  end

  // Receive state machine; a stop bit sampled low becomes the next start.
  // The bit timer runs free inside a frame and is realigned at the middle of
  // the start bit, so data and parity samples land near the centre of their bits;
  // the stop check at mid_bit lands at the start of the stop bit.
  // Data bits are taken at the end of each bit period after that realignment,
  // which is again the centre of the incoming bit. A break forces the
  // machine back to idle, and idle waits for the line to rise before it may
  // start again, since brk_armed_q stays low for the rest of the low period.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      st_q      <= ULMS_RX_IDLE;
      bit_cnt_q <= 16'h0000;
      nbit_q    <= 4'h0;
      shift_q   <= 8'h00;
      par_acc_q <= 1'b0;
    end else begin
      bit_cnt_q <= bit_end ? 16'h0000 : bit_cnt_q + 16'h0001;
      case (st_q)
        ULMS_RX_IDLE: begin
          bit_cnt_q <= 16'h0000;
          if (!I_RX_SERIAL && brk_armed_q) begin
            st_q <= ULMS_RX_START;
          end
        end
        ULMS_RX_START: begin
          if (mid_bit) begin
            if (I_RX_SERIAL) begin
              st_q <= ULMS_RX_IDLE;
            end else begin
              bit_cnt_q <= 16'h0000;
              nbit_q    <= 4'h0;
              par_acc_q <= 1'b0;
              st_q      <= ULMS_RX_DATA;
            end
          end
        end
        ULMS_RX_DATA: begin
          if (bit_end) begin
            shift_q   <= {I_RX_SERIAL, shift_q[7:1]};
            par_acc_q <= par_acc_q ^ I_RX_SERIAL;
            nbit_q    <= nbit_q + 4'h1;
            if (nbit_q == 4'(`ULMS_DATA_BITS - 1)) begin
              st_q <= par_en ? ULMS_RX_PARITY : ULMS_RX_STOP;
            end
          end
        end
        ULMS_RX_PARITY: begin
          if (bit_end) begin
            par_acc_q <= par_acc_q ^ I_RX_SERIAL ^ 1'b1;   // Odd parity sense.
            st_q      <= ULMS_RX_STOP;
          end
        end
        ULMS_RX_STOP: begin
          if (bit_end) begin
            bit_cnt_q <= 16'h0000;
            st_q      <= I_RX_SERIAL ? ULMS_RX_IDLE : ULMS_RX_START;
          end
        end
        default: st_q <= ULMS_RX_IDLE;
      endcase
      if (brk_hit) begin
        st_q <= ULMS_RX_IDLE;
      end
    end
  end

  // Receive FIFO bookkeeping and holding register. The store has a registered
  // read port, so the read address runs one entry ahead during a pop; the new
  // head is then ready in the cycle after the pop. Only one of FIFO and holding
  // register is live at a time, chosen by the FIFO enable bit.
  ulms_mem_if mif ();
  ulms_mem u_mem (
    .i_clk (I_CORE_CLK),
    .port  (mif.mem)
  );

  logic [`ULMS_FIFO_AW-1:0] wp_q;
  logic [`ULMS_FIFO_AW-1:0] rp_q;
  logic [`ULMS_FIFO_AW:0]   cnt_q;
  ulms_entry_s              hold_q;
  logic                     hold_full_q;

  wire fifo_full  = (cnt_q == 5'(`ULMS_FIFO_DEPTH));
  wire fifo_empty = (cnt_q == 5'h00);
  wire push       = fifo_en & char_done & ~fifo_full;
  wire pop        = fifo_en & rd_rx & ~fifo_empty;
  // Registered read data: the head entry is valid one cycle after pointers settle.
  assign mif.we    = push;
  assign mif.waddr = wp_q;
  assign mif.wdata = new_ch;
  assign mif.raddr = pop ? rp_q + 4'h1 : rp_q;
  wire ulms_entry_s head = fifo_en ? mif.rdata : hold_q;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || (wr_ctl && (I_WB_DAT[`ULMS_CTL_FIFO_EN] != fifo_en))) begin
      wp_q  <= 4'h0;
      rp_q  <= 4'h0;
      cnt_q <= 5'h00;
    end else begin
      wp_q  <= push ? wp_q + 4'h1 : wp_q;
      rp_q  <= pop ? rp_q + 4'h1 : rp_q;
      cnt_q <= cnt_q + {4'h0, push} - {4'h0, pop};
    end
  end

  // Without FIFO the holding register is simply overwritten.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      hold_q      <= '0;
      hold_full_q <= 1'b0;
    end else if (!fifo_en && char_done) begin
      hold_q      <= new_ch;
      hold_full_q <= 1'b1;
    end else if (!fifo_en && rd_rx) begin
      hold_full_q <= 1'b0;
    end
  end

  // Error marks of the head entry, revealed once it is at the head.
  logic head_ok_q;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      head_ok_q <= 1'b0;
    end else begin
      head_ok_q <= fifo_en & ~fifo_empty & ~pop & ~push;
    end
  end
  wire head_seen  = fifo_en ? (head_ok_q & ~fifo_empty) : 1'b0;

  // Each head entry reveals its marks once, and again after each push. Without this the entry sitting at
  // the head would raise its marks again in every cycle, and a line status
  // read could never clear them while that entry waits to be popped.
  logic head_shown_q;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      head_shown_q <= 1'b0;
    end else begin
      head_shown_q <= head_seen;
    end
  end
  wire head_new   = head_seen & ~head_shown_q;

  wire ovr_ev     = char_done & (fifo_en ? fifo_full : hold_full_q);
  wire frm_ev     = fifo_en ? (head_new & head.frm) : (char_done & new_ch.frm);
  wire par_ev     = fifo_en ? (head_new & head.par) : (char_done & new_ch.par);
  wire brk_ev     = fifo_en ? (head_new & head.brk) : (char_done & new_ch.brk);

  // Sticky line flags: the event term is ORed in so it wins over the read.
  logic ovr_q;
  logic frm_q;
  logic par_q;
  logic brk_q;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      ovr_q <= 1'b0;
      frm_q <= 1'b0;
      par_q <= 1'b0;
      brk_q <= 1'b0;
    end else begin
      ovr_q <= ovr_ev | (ovr_q & ~rd_ls);
      frm_q <= frm_ev | (frm_q & ~rd_ls);
      par_q <= par_ev | (par_q & ~rd_ls);
      brk_q <= brk_ev | (brk_q & ~rd_ls);
    end
  end
  wire dr      = fifo_en ? ~fifo_empty : hold_full_q;
  wire fifo_er = fifo_en & (frm_q | par_q | brk_q);

  // Modem status: the watched source swaps to request-to-send in loopback.
  // The change detector compares against cts_q, which reset leaves at the
  // idle (deasserted) level. An input still asserted at release therefore
  // looks like a change and sets the delta flag one cycle later. Entering or
  // leaving loopback can also count as a change when the two sources differ.
  wire cts_src = loopback ? rts_bit : ~I_CTS_N;
  logic cts_q;
  logic dcts_q;
  logic rst_seen_q;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      cts_q      <= 1'b0;
      dcts_q     <= 1'b0;
      rst_seen_q <= 1'b1;
    end else begin
      cts_q      <= cts_src;
      rst_seen_q <= 1'b0;
      // After release a still-asserted input counts as a change from idle.
      dcts_q     <= (cts_src != cts_q) | (dcts_q & ~rd_ms);
    end
  end

  // Read mux and single-cycle acknowledge. Read data is zero outside the ack
  // cycle, so a master that samples late sees zero, not stale status.
  // Reserved bits of both status words always read as zero.
  wire [15:0] ls_word = {8'h00, fifo_er, 2'b00, brk_q, frm_q, par_q, ovr_q, dr};
  wire [15:0] ms_word = {11'h000, cts_q, 3'b000, dcts_q};
  wire [31:0] rd_word = hit_ls  ? {16'h0000, ls_word} :
                        hit_ms  ? {16'h0000, ms_word} :
                        hit_ctl ? {28'h000_0000, ctl_q} :
                        hit_rx  ? {24'h00_0000, head.data} : 32'h0000_0000;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0000_0000;
    end else begin
      O_WB_ACK <= bus_req;
      O_WB_DAT <= (bus_req && !I_WB_WE) ? rd_word : 32'h0000_0000;
    end
  end
endmodule : ulms_top

// *** bench/ulms_top_monitor.sv ***
/*
  Port checker for the line and modem status block.
  Assumes it is bound to ulms_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`include "ulms_cfg.svh"
module ulms_top_monitor
  import ulms_pkg::*;
(
  input wire logic                 I_CORE_CLK,
  input wire logic                 I_RST,
  input wire logic                 I_RX_SERIAL,
  input wire logic                 I_CTS_N,
  input wire logic                 I_WB_CYC,
  input wire logic                 I_WB_STB,
  input wire logic                 I_WB_WE,
  input wire ulms_pkg::ulms_sel_t  I_WB_SEL,
  input wire ulms_pkg::ulms_word_t I_WB_ADR,
  input wire ulms_pkg::ulms_word_t I_WB_DAT,
  input wire logic                 O_WB_ACK,
  input wire ulms_pkg::ulms_word_t O_WB_DAT,
  input wire logic                 O_RTS_N
);
  // The master holds the address until ack, so it still names the target there.
  wire logic take   = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  wire logic rd_ack = O_WB_ACK && !I_WB_WE;
  wire logic ls_ack = rd_ack && (I_WB_ADR == `ULMS_LINE_STATUS_ADDR);
  wire logic ms_ack = rd_ack && (I_WB_ADR == `ULMS_MODEM_STATUS_ADDR);
  wire logic ctl_wr = O_WB_ACK && I_WB_WE && I_WB_SEL[0] && (I_WB_ADR == `ULMS_CONTROL_ADDR);
  logic lb_q;
  logic rts_q;
  // Shadow of loopback and request-to-send, updated as a control write completes.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      lb_q  <= 1'b0;
      rts_q <= 1'b0;
    end else if (ctl_wr) begin
      lb_q  <= I_WB_DAT[`ULMS_CTL_LOOPBACK];
      rts_q <= I_WB_DAT[`ULMS_CTL_RTS];
    end
  end
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  // Two status reads in a row with a quiet line; no new error can arise between them.
  sequence ls_twice;
    ls_ack ##1 (!O_WB_ACK && I_RX_SERIAL) [*2] ##1 (ls_ack && I_RX_SERIAL);
  endsequence
  ack_follows_a: assert property (take |=> O_WB_ACK)
    else $error("request not acknowledged in the next cycle");
  ack_single_a: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack held longer than one cycle");
  idle_zero_a: assert property (!O_WB_ACK |-> O_WB_DAT == '0)
    else $error("read data shown without ack");
  break_fe_a: assert property (ls_ack && O_WB_DAT[4] |-> O_WB_DAT[3])
    else $error("break shown without framing error");
  break_pe_a: assert property (ls_ack && O_WB_DAT[4] |-> O_WB_DAT[2])
    else $error("break shown without parity error");
  ls_clear_a: assert property (ls_twice |-> O_WB_DAT[0] || O_WB_DAT[4:1] == 4'h0)
    else $error("error flags survived a status read");
  cts_bit_a: assert property (ms_ack && !lb_q && !$past(lb_q, 3) && $stable(I_CTS_N)
    && $past(I_CTS_N, 3) == I_CTS_N |-> O_WB_DAT[4] == !I_CTS_N)
    else $error("clear-to-send bit not inverse of input");
  loop_cts_a: assert property (ms_ack && lb_q && $past(lb_q, 3)
    && $past(rts_q, 3) == rts_q |-> O_WB_DAT[4] == rts_q)
    else $error("loopback clear-to-send does not follow request-to-send");
  rts_pin_a: assert property ($stable(lb_q) && $past(lb_q, 2) == lb_q && $stable(rts_q)
    && $past(rts_q, 2) == rts_q |-> O_RTS_N == (lb_q || !rts_q))
    else $error("request-to-send pin wrong");
endmodule : ulms_top_monitor
bind ulms_top ulms_top_monitor u_ulms_top_monitor (
  .I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_RX_SERIAL(I_RX_SERIAL), .I_CTS_N(I_CTS_N),
  .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_SEL(I_WB_SEL),
  .I_WB_ADR(I_WB_ADR), .I_WB_DAT(I_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_WB_DAT(O_WB_DAT),
  .O_RTS_N(O_RTS_N)
);

// *** bench/ulms_peer.sv ***
/*
  Serial peer: drives the receive line and clear-to-send into the block.
  Assumes the bench calls its tasks and that it shares the block's clock.
*/
`timescale 1ns/1ps
`include "ulms_cfg.svh"
module ulms_peer (
  input  wire logic i_clk,
  output logic      o_rx,
  output logic      o_cts_n
);
  // Idle line high; clear-to-send starts asserted so reset release sees it low.
  initial begin
    o_rx    = 1'b1;
    o_cts_n = 1'b0;
  end
  // One level for whole bit times, changed just after a clock edge.
  task automatic bit_out(input logic b, input int n);
    o_rx <= b;
    repeat (n * `ULMS_BIT_CYCLES) @(posedge i_clk);
  endtask : bit_out
  // Start, data low bit first, optional odd parity (or its inverse), stop, idle gap.
  task automatic send(input logic [7:0] d, input logic par_on, input logic par_bad,
                      input logic stop);
    @(posedge i_clk);
    bit_out(1'b0, 1);
    for (int i = 0; i < `ULMS_DATA_BITS; i++) bit_out(d[i], 1);
    if (par_on) bit_out(~^d ^ par_bad, 1);
    bit_out(stop, 1);
    bit_out(1'b1, 2);
  endtask : send
  // Low well past a whole character time, then back to idle.
  task automatic brk();
    @(posedge i_clk);
    bit_out(1'b0, 12);
    bit_out(1'b1, 2);
  endtask : brk
  task automatic set_cts(input logic v);
    @(posedge i_clk);
    o_cts_n <= v;
  endtask : set_cts
endmodule : ulms_peer

// *** bench/ulms_line_modem_status_tb.sv ***
/*
  Self-checking bench: register reads and writes over classic Wishbone.
  Assumes the serial peer model and the bound port checker.
*/
`timescale 1ns/1ps
`include "ulms_cfg.svh"
module uart_line_modem_status_tb;
  import ulms_pkg::*;
  localparam ulms_word_t ls_a  = `ULMS_LINE_STATUS_ADDR;
  localparam ulms_word_t ms_a  = `ULMS_MODEM_STATUS_ADDR;
  localparam ulms_word_t ctl_a = `ULMS_CONTROL_ADDR;
  localparam ulms_word_t rxd_a = `ULMS_RX_DATA_ADDR;
  logic       clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  ulms_sel_t  sel = 4'h0;
  ulms_word_t adr = '0, wdat = '0, rdat;
  wire logic  ack, rts_n, rx, cts_n;
  ulms_word_t odat;
  int         miscompares = 0, compares = 0;
  ulms_top u_ulms_top (.I_CORE_CLK(clk), .I_RST(rst), .I_RX_SERIAL(rx), .I_CTS_N(cts_n),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_SEL(sel), .I_WB_ADR(adr),
    .I_WB_DAT(wdat), .O_WB_ACK(ack), .O_WB_DAT(odat), .O_RTS_N(rts_n));
  ulms_peer u_ulms_peer (.i_clk(clk), .o_rx(rx), .o_cts_n(cts_n));
  // Free-running 25 MHz clock.
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // One classic cycle; request held until ack is sampled, then dropped for a cycle.
  task automatic wb(input logic w, input ulms_word_t a, input ulms_word_t d);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    @(posedge clk);
    while (ack !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
    end
    if (n == 100) begin
      miscompares++;
      $display("FAIL %0t ack timeout got %h exp %h", $time, ack, 1'b1);
      print_verdict();
    end
    rdat = odat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask : wb
  // Read a register and compare the masked value.
  task automatic rd(input ulms_word_t a, input ulms_word_t e, input ulms_word_t m = '1);
    wb(1'b0, a, '0);
    compares++;
    if ((rdat & m) !== e) begin
      miscompares++;
      $display("FAIL %0t addr %h got %h exp %h", $time, a, rdat & m, e);
    end
  endtask : rd
  // Main sequence: modem status, loopback, plain receive, errors, FIFO mode.
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(ms_a, 32'h0000_0011);
    rd(ms_a, 32'h0000_0010);
    rd(ls_a, 32'h0000_0000);
    rd(32'h5000_111C, 32'h0000_0000);
    u_ulms_peer.set_cts(1'b1);
    repeat (4) @(posedge clk);
    rd(ms_a, 32'h0000_0001);
    wb(1'b1, ctl_a, 32'h0000_000C);
    rd(ms_a, 32'h0000_0011);
    rd(ms_a, 32'h0000_0010);
    wb(1'b1, ctl_a, 32'h0000_0008);
    rd(ms_a, 32'h0000_0001);
    wb(1'b1, ctl_a, 32'h0000_0000);
    rd(ms_a, 32'h0000_0000);
    $display("test modem done");
    u_ulms_peer.send(8'hA5, 1'b0, 1'b0, 1'b1);
    rd(ls_a, 32'h0000_0001);
    rd(ls_a, 32'h0000_0001);
    rd(rxd_a, 32'h0000_00A5);
    rd(ls_a, 32'h0000_0000);
    u_ulms_peer.send(8'h3C, 1'b0, 1'b0, 1'b1);
    u_ulms_peer.send(8'hC3, 1'b0, 1'b0, 1'b1);
    rd(ls_a, 32'h0000_0003);
    rd(ls_a, 32'h0000_0001);
    rd(rxd_a, 32'h0000_00C3);
    u_ulms_peer.send(8'h0F, 1'b0, 1'b0, 1'b0);
    rd(ls_a, 32'h0000_0008, 32'h0000_0008);
    rd(ls_a, 32'h0000_0000, 32'h0000_000E);
    rd(rxd_a, 32'h0000_000F);
    u_ulms_peer.send(8'h01, 1'b1, 1'b1, 1'b1);
    rd(ls_a, 32'h0000_0001);
    rd(rxd_a, 32'h0000_0001);
    wb(1'b1, ctl_a, 32'h0000_0002);
    u_ulms_peer.send(8'h01, 1'b1, 1'b1, 1'b1);
    rd(ls_a, 32'h0000_0005);
    rd(rxd_a, 32'h0000_0001);
    wb(1'b1, ctl_a, 32'h0000_0000);
    u_ulms_peer.brk();
    rd(ls_a, 32'h0000_001D);
    rd(rxd_a, 32'h0000_0000);
    $display("test line errors done");
    wb(1'b1, ctl_a, 32'h0000_0003);
    u_ulms_peer.send(8'h11, 1'b1, 1'b0, 1'b1);
    u_ulms_peer.send(8'h01, 1'b1, 1'b1, 1'b1);
    rd(ls_a, 32'h0000_0001, 32'h0000_000D);
    rd(rxd_a, 32'h0000_0011);
    repeat (4) @(posedge clk);
    rd(ls_a, 32'h0000_0005, 32'h0000_000D);
    rd(rxd_a, 32'h0000_0001);
    wb(1'b1, ctl_a, 32'h0000_0001);
    rd(ls_a, 32'h0000_0000, 32'h0000_000F);
    for (int i = 0; i < 17; i++) u_ulms_peer.send(8'h40 + i[7:0], 1'b0, 1'b0, 1'b1);
    rd(ls_a, 32'h0000_0003, 32'h0000_000F);
    for (int i = 0; i < 16; i++) rd(rxd_a, 32'h0000_0040 + i);
    rd(ls_a, 32'h0000_0000, 32'h0000_000F);
    $display("test fifo done");
    print_verdict();
  end
endmodule : uart_line_modem_status_tb
